// ===== hdl/rtbe_encoder.sv
// Purpose: line coder and backscatter modulator of a passive tag
// Assumes: carrier_clk_i is the recovered carrier, far slower than core_clk_i
// Notes: mod_o high turns the damping transistor on
//
// Functional notes
// - direct coding outputs stored bit for whole period
// - split phase flips mid bit, one falls
// - space biphase toggles at start on one
// - space biphase holds level at start on zero
// - direct modulation envelope follows coded level
// - fsk zero uses eight cycle square wave
// - fsk one uses ten cycle square wave
// - fsk works with direct level coding
// - psk uses one subcarrier, phase inverts
// - first psk inverts phase on zero bits
// - second psk inverts phase on bit change
// - psk subcarrier period two carrier cycles
// - array bits clocked out in sequence
// - all timing from recovered carrier clock
// - straps pick modulation, coding, rate, length
`timescale 1ns/100ps
module rtbe_encoder (
   // clock and power-on reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // recovered carrier
   input wire logic carrier_clk_i,
   // configuration straps
   input wire logic [1:0] cfg_mod_i,
   input wire logic [1:0] cfg_code_i,
   input wire logic [2:0] cfg_rate_i,
   input wire logic [1:0] cfg_len_i,
   // array programming, same clock
   input wire logic prog_we_i,
   input wire logic [6:0] prog_addr_i,
   input wire logic prog_bit_i,
   // modulation transistor and status
   output logic mod_o,
   output logic tx_active_o
);
   logic mem [rtbe_pkg::RTBE_MEM_BITS];

   logic car_meta_reg, car_meta_next;
   logic car_sync_reg, car_sync_next;
   logic car_prev_reg, car_prev_next;
   logic [8:0] cfg_meta_reg, cfg_meta_next;
   logic [8:0] cfg_sync_reg, cfg_sync_next;
   logic tick;

   rtbe_pkg::rtbe_mod_t mod_sel;
   rtbe_pkg::rtbe_code_t code_sel;
   logic [7:0] bit_per;
   logic [7:0] bit_len;

   logic fill_en_reg, fill_en_next;
   logic [6:0] rd_ptr_reg, rd_ptr_next;
   logic push;

   rtbe_pkg::rtbe_state_t state_reg, state_next;
   logic [7:0] bit_cnt_reg, bit_cnt_next;
   logic data_bit_reg, data_bit_next;
   logic prev_bit_reg, prev_bit_next;
   logic level_reg, level_next;
   logic phase_reg, phase_next;
   logic [3:0] sub_cnt_reg, sub_cnt_next;
   logic psk_sq_reg, psk_sq_next;
   logic mod_reg, mod_next;
   logic tx_active_reg, tx_active_next;
   logic end_bit;
   logic start;
   logic mid;
   logic pop;
   logic fifo_bit;
   logic [3:0] fsk_per;
   rtbe_stream_if #(.WIDTH(rtbe_pkg::RTBE_FIFO_WIDTH)) fill_if ();
   rtbe_stream_if #(.WIDTH(rtbe_pkg::RTBE_FIFO_WIDTH)) drain_if ();

   rtbe_fifo #(
      .WIDTH(rtbe_pkg::RTBE_FIFO_WIDTH),
      .DEPTH(rtbe_pkg::RTBE_FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .fill_if(fill_if),
      .drain_if(drain_if)
   );

   // carrier and straps come from outside, two flops first
   always_comb begin
      car_meta_next = carrier_clk_i;
      car_sync_next = car_meta_reg;
      car_prev_next = car_sync_reg;
      cfg_meta_next = {cfg_len_i, cfg_rate_i, cfg_code_i, cfg_mod_i};
      cfg_sync_next = cfg_meta_reg;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         car_meta_reg <= 1'b0;
         car_sync_reg <= 1'b0;
         car_prev_reg <= 1'b0;
         cfg_meta_reg <= '0;
         cfg_sync_reg <= '0;
      end else begin
         car_meta_reg <= car_meta_next;
         car_sync_reg <= car_sync_next;
         car_prev_reg <= car_prev_next;
         cfg_meta_reg <= cfg_meta_next;
         cfg_sync_reg <= cfg_sync_next;
      end
   end

   // one enable per carrier rising edge drives the bit and subcarrier counts
   assign tick = car_sync_reg & ~car_prev_reg;

   // straps are meant static; changing them mid frame can garble many bits, since the bit counter or array pointer can overrun and wrap
   assign mod_sel = rtbe_pkg::rtbe_mod_t'(cfg_sync_reg[1:0]);
   assign code_sel = rtbe_pkg::rtbe_code_t'(cfg_sync_reg[3:2]);
   assign bit_per = rtbe_pkg::RTBE_RATE_TBL[cfg_sync_reg[6:4]];
   assign bit_len = rtbe_pkg::RTBE_LEN_TBL[cfg_sync_reg[8:7]];

   // otp array; contents only defined once programmed
   always_ff @(posedge core_clk_i) begin
      if (prog_we_i) begin
         mem[prog_addr_i] <= prog_bit_i;
      end
   end

   // array reader keeps the buffer topped up, stalls while it is full
   assign fill_if.valid = fill_en_reg;
   assign fill_if.data = mem[rd_ptr_reg];
   assign push = fill_if.valid & fill_if.ready;

   always_comb begin
      fill_en_next = 1'b1;
      rd_ptr_next = rd_ptr_reg;
      if (push) begin
         rd_ptr_next = ({1'b0, rd_ptr_reg} == bit_len - 8'h01) ? 7'h00 : rd_ptr_reg + 7'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         fill_en_reg <= 1'b0;
         rd_ptr_reg <= 7'h00;
      end else begin
         fill_en_reg <= fill_en_next;
         rd_ptr_reg <= rd_ptr_next;
      end
   end

   // encoder and modulator
   assign end_bit = (bit_cnt_reg == bit_per - 8'h01);
   assign fifo_bit = drain_if.data[0];
   assign drain_if.ready = pop;

   always_comb begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      data_bit_next = data_bit_reg;
      prev_bit_next = prev_bit_reg;
      level_next = level_reg;
      phase_next = phase_reg;
      sub_cnt_next = sub_cnt_reg;
      psk_sq_next = psk_sq_reg;
      mod_next = mod_reg;
      fsk_per = rtbe_pkg::RTBE_FSK_ZERO_PER;
      start = 1'b0;
      mid = 1'b0;
      pop = 1'b0;
      if (tick) begin
         case (state_reg)
            rtbe_pkg::RTBE_ST_IDLE: begin
               if (drain_if.valid) begin
                  start = 1'b1;
                  state_next = rtbe_pkg::RTBE_ST_RUN;
               end
            end
            rtbe_pkg::RTBE_ST_RUN: begin
               if (end_bit) begin
                  if (drain_if.valid) begin
                     start = 1'b1;
                  end else begin
                     state_next = rtbe_pkg::RTBE_ST_IDLE;
                  end
               end else begin
                  bit_cnt_next = bit_cnt_reg + 8'h01;
                  mid = (bit_cnt_reg == {1'b0, bit_per[7:1]} - 8'h01);
               end
            end
            default: begin
               state_next = rtbe_pkg::RTBE_ST_IDLE;
            end
         endcase
         if (start) begin
            pop = 1'b1;
            bit_cnt_next = rtbe_pkg::RTBE_RST_CNT;
            data_bit_next = fifo_bit;
            prev_bit_next = data_bit_reg;
            if (code_sel == rtbe_pkg::RTBE_CODE_BPS) begin
               level_next = level_reg ^ fifo_bit;
            end else begin
               level_next = fifo_bit;
            end
            if (mod_sel == rtbe_pkg::RTBE_MOD_PSK1) begin
               phase_next = phase_reg ^ ~fifo_bit;
            end else if (mod_sel == rtbe_pkg::RTBE_MOD_PSK2) begin
               phase_next = phase_reg ^ (fifo_bit ^ data_bit_reg);
            end
         end else if (mid) begin
            if (code_sel == rtbe_pkg::RTBE_CODE_SPLIT || code_sel == rtbe_pkg::RTBE_CODE_BPS) begin
               level_next = ~level_reg;
            end
         end
         fsk_per = level_next ? rtbe_pkg::RTBE_FSK_ONE_PER : rtbe_pkg::RTBE_FSK_ZERO_PER;
         // subcarrier restarts on each level change so periods stay whole
         if (start || level_next != level_reg || sub_cnt_reg >= fsk_per - 4'h1) begin
            sub_cnt_next = rtbe_pkg::RTBE_RST_SUB;
         end else begin
            sub_cnt_next = sub_cnt_reg + 4'h1;
         end
         psk_sq_next = ~psk_sq_reg;
         if (state_next != rtbe_pkg::RTBE_ST_RUN) begin
            mod_next = rtbe_pkg::RTBE_RST_MOD;
         end else begin
            case (mod_sel)
               rtbe_pkg::RTBE_MOD_DIRECT: mod_next = ~level_next;
               rtbe_pkg::RTBE_MOD_FSK: mod_next = (sub_cnt_next < {1'b0, fsk_per[3:1]});
               rtbe_pkg::RTBE_MOD_PSK1: mod_next = psk_sq_next ^ phase_next;
               rtbe_pkg::RTBE_MOD_PSK2: mod_next = psk_sq_next ^ phase_next;
               default: mod_next = rtbe_pkg::RTBE_RST_MOD;
            endcase
         end
      end
      tx_active_next = (state_next == rtbe_pkg::RTBE_ST_RUN);
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= rtbe_pkg::RTBE_ST_IDLE;
         bit_cnt_reg <= rtbe_pkg::RTBE_RST_CNT;
         data_bit_reg <= 1'b0;
         prev_bit_reg <= 1'b0;
         level_reg <= rtbe_pkg::RTBE_RST_LEVEL;
         phase_reg <= 1'b0;
         sub_cnt_reg <= rtbe_pkg::RTBE_RST_SUB;
         psk_sq_reg <= 1'b0;
         mod_reg <= rtbe_pkg::RTBE_RST_MOD;
         tx_active_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         data_bit_reg <= data_bit_next;
         prev_bit_reg <= prev_bit_next;
         level_reg <= level_next;
         phase_reg <= phase_next;
         sub_cnt_reg <= sub_cnt_next;
         psk_sq_reg <= psk_sq_next;
         mod_reg <= mod_next;
         tx_active_reg <= tx_active_next;
      end
   end

   assign mod_o = mod_reg;
   assign tx_active_o = tx_active_reg;

   // checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   logic running;
   assign running = (state_reg == rtbe_pkg::RTBE_ST_RUN);
   sequence s_bit_start;
      tick && start;
   endsequence
   sequence s_mid_bit;
      tick && mid;
   endsequence
   property p_rst_quiet;
      @(posedge core_clk_i) disable iff (1'b0) sys_rst_i |=> !mod_o && !tx_active_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
   property p_nrz_level;
      running && code_sel == rtbe_pkg::RTBE_CODE_NRZ |-> level_reg == data_bit_reg;
   endproperty
   a_nrz_level: assert property (p_nrz_level) else $error("nrz level differs from bit");
   property p_split_level;
      running && code_sel == rtbe_pkg::RTBE_CODE_SPLIT
         |-> (level_reg == data_bit_reg) == (bit_cnt_reg < {1'b0, bit_per[7:1]});
   endproperty
   a_split_level: assert property (p_split_level) else $error("split phase level wrong");
   property p_bps_start;
      s_bit_start and code_sel == rtbe_pkg::RTBE_CODE_BPS
         |=> level_reg == ($past(level_reg) ^ data_bit_reg);
   endproperty
   a_bps_start: assert property (p_bps_start) else $error("biphase start edge wrong");
   property p_bps_mid;
      s_mid_bit and code_sel == rtbe_pkg::RTBE_CODE_BPS |=> level_reg != $past(level_reg);
   endproperty
   a_bps_mid: assert property (p_bps_mid) else $error("biphase mid toggle missing");
   property p_fsk_zero;
      running && mod_sel == rtbe_pkg::RTBE_MOD_FSK && !level_reg
         |-> sub_cnt_reg < rtbe_pkg::RTBE_FSK_ZERO_PER && mod_o == (sub_cnt_reg < 4'h4);
   endproperty
   a_fsk_zero: assert property (p_fsk_zero) else $error("fsk zero period wrong");
   property p_fsk_one;
      running && mod_sel == rtbe_pkg::RTBE_MOD_FSK && level_reg
         |-> sub_cnt_reg < rtbe_pkg::RTBE_FSK_ONE_PER && mod_o == (sub_cnt_reg < 4'h5);
   endproperty
   a_fsk_one: assert property (p_fsk_one) else $error("fsk one period wrong");
   property p_psk_toggle;
      tick && running && !end_bit && mod_sel[1] |=> mod_o != $past(mod_o);
   endproperty
   a_psk_toggle: assert property (p_psk_toggle) else $error("psk subcarrier not half rate");
   property p_psk1_phase;
      s_bit_start and mod_sel == rtbe_pkg::RTBE_MOD_PSK1 and !fifo_bit |=> $changed(phase_reg);
   endproperty
   a_psk1_phase: assert property (p_psk1_phase) else $error("psk1 phase not inverted");
   property p_psk2_phase;
      s_bit_start and mod_sel == rtbe_pkg::RTBE_MOD_PSK2
         |=> phase_reg == ($past(phase_reg) ^ (data_bit_reg ^ prev_bit_reg));
   endproperty
   a_psk2_phase: assert property (p_psk2_phase) else $error("psk2 phase wrong");
   property p_wrap;
      push && ({1'b0, rd_ptr_reg} == bit_len - 8'h01) |=> rd_ptr_reg == 7'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("array pointer did not wrap");
   property p_bit_end;
      tick && running && end_bit && drain_if.valid |=> bit_cnt_reg == 8'h00 ##1 bit_cnt_reg == 8'h00;
   endproperty
   a_bit_end: assert property (p_bit_end) else $error("bit counter did not restart");

endmodule

// ===== hdl/rtbe_fifo.sv
// Purpose: bit buffer between the data array reader and the line encoder
// Assumes: synchronous active high reset
// Notes: full blocks the filler, empty stalls the drain
`timescale 1ns/100ps
module rtbe_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // filling side
   rtbe_stream_if.snk fill_if,
   // draining side
   rtbe_stream_if.src drain_if
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] wr_ptr_next;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW-1:0] rd_ptr_next;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic push;
   logic pop;

   assign fill_if.ready = (count_reg != (AW+1)'(DEPTH));
   assign drain_if.valid = (count_reg != '0);
   assign drain_if.data = mem[rd_ptr_reg];
   assign push = fill_if.valid & fill_if.ready;
   assign pop = drain_if.valid & drain_if.ready;

   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      if (push) begin
         wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
         rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end

   // storage carries no reset; the count alone says what is valid
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= fill_if.data;
      end
   end

endmodule

// ===== hdl/rtbe_pkg.sv
// Purpose: shared constants and types of the tag bit encoder and modulator
// Assumes: timing counted in recovered carrier cycles
// Notes: tables are packed so index 0 is the rightmost entry
package rtbe_pkg;

   typedef enum logic [1:0] {
      RTBE_MOD_DIRECT = 2'b00,
      RTBE_MOD_FSK = 2'b01,
      RTBE_MOD_PSK1 = 2'b10,
      RTBE_MOD_PSK2 = 2'b11
   } rtbe_mod_t;

   typedef enum logic [1:0] {
      RTBE_CODE_NRZ = 2'b00,
      RTBE_CODE_SPLIT = 2'b01,
      RTBE_CODE_BPS = 2'b10,
      RTBE_CODE_RSVD = 2'b11
   } rtbe_code_t;

   typedef enum logic [0:0] {
      RTBE_ST_IDLE = 1'b0,
      RTBE_ST_RUN = 1'b1
   } rtbe_state_t;

   // data array and buffer
   localparam int RTBE_MEM_BITS = 128;
   localparam int RTBE_ADDR_W = 7;
   localparam int RTBE_FIFO_DEPTH = 32;
   localparam int RTBE_FIFO_WIDTH = 1;

   // fsk subcarrier periods in carrier cycles
   localparam logic [3:0] RTBE_FSK_ZERO_PER = 4'h8;
   localparam logic [3:0] RTBE_FSK_ONE_PER = 4'ha;

   // bit period in carrier cycles, selected by the rate strap; all even
   localparam logic [7:0][7:0] RTBE_RATE_TBL = {
      8'h80, 8'h64, 8'h50, 8'h40, 8'h32, 8'h28, 8'h20, 8'h10
   };

   // bits sent per loop, selected by the length strap
   localparam logic [3:0][7:0] RTBE_LEN_TBL = {8'h80, 8'h80, 8'h60, 8'h40};

   // reset values
   localparam logic RTBE_RST_MOD = 1'b0;
   localparam logic RTBE_RST_LEVEL = 1'b0;
   localparam logic [7:0] RTBE_RST_CNT = 8'h00;
   localparam logic [3:0] RTBE_RST_SUB = 4'h0;

endpackage

// ===== hdl/rtbe_stream_if.sv
// Purpose: valid/ready stream between array reader, buffer and encoder
// Assumes: one clock, transfer on valid and ready high at a rising edge
// Notes: width is a parameter
`timescale 1ns/100ps
interface rtbe_stream_if #(parameter int WIDTH = 1) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ===== testbench/rfid_tag_bit_encoder_modulator_test.sv
// Purpose: self-checking bench of the tag line coder and modulator
// Assumes: array programmed once, straps changed only under reset
// Notes: expectations rebuilt per carrier tick from the coding rules
`timescale 1ns/100ps
module rfid_tag_bit_encoder_modulator_test;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic carrier_clk;
   logic [1:0] cfg_mod = 2'b00;
   logic [1:0] cfg_code = 2'b00;
   logic [2:0] cfg_rate = 3'h0;
   logic [1:0] cfg_len = 2'b00;
   logic prog_we = 1'b0;
   logic [6:0] prog_addr = 7'h00;
   logic prog_bit = 1'b0;
   logic mod_o;
   logic tx_active_o;
   int fail_count = 0;
   int n_tests = 0;
   // runs of both values so whole fsk periods appear
   logic [127:0] pat = 128'h0f3c_a5e1_96d2_7b48_00ff_3c3c_e718_5a69;

   always #4 core_clk_i = ~core_clk_i;

   rtbe_encoder DUT (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .carrier_clk_i(carrier_clk),
      .cfg_mod_i(cfg_mod),
      .cfg_code_i(cfg_code),
      .cfg_rate_i(cfg_rate),
      .cfg_len_i(cfg_len),
      .prog_we_i(prog_we),
      .prog_addr_i(prog_addr),
      .prog_bit_i(prog_bit),
      .mod_o(mod_o),
      .tx_active_o(tx_active_o)
   );

   rtbe_reader_model model (
      .carrier_clk_o(carrier_clk),
      .rst_i(sys_rst_i),
      .mod_i(mod_o),
      .tx_active_i(tx_active_o)
   );

   task automatic check(input logic seen, input logic exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] md, cd, input logic [2:0] rt, input logic [1:0] ln);
      @(negedge core_clk_i);
      sys_rst_i = 1'b1;
      cfg_mod = md;
      cfg_code = cd;
      cfg_rate = rt;
      cfg_len = ln;
      repeat (3) @(negedge core_clk_i);
      check(mod_o, 1'b0);
      check(tx_active_o, 1'b0);
      sys_rst_i = 1'b0;
   endtask

   // p ticks a bit, len bits a loop, nb bits checked
   task automatic run_case(input logic [1:0] md, cd, input logic [2:0] rt, input logic [1:0] ln,
                           input int p, len, nb);
      int s, k, b, cnt, sc, per, n;
      logic lvl, plvl, bv, pbit, flip, m;
      do_reset(md, cd, rt, ln);
      n = 0;
      while (model.act_q.size() < 8 + nb * p && n < 40000) begin
         @(negedge core_clk_i);
         n++;
      end
      check(model.act_q.size() >= 8 + nb * p, 1'b1);
      s = 0;
      while (s < 8 && model.act_q[s] !== 1'b1) begin
         check(model.mod_q[s], 1'b0);
         s++;
      end
      lvl = 1'b0;
      pbit = 1'b0;
      sc = 0;
      for (k = 0; k < nb * p; k++) begin
         b = (k / p) % len;
         cnt = k % p;
         bv = pat[b];
         plvl = lvl;
         case (cd)
            2'b01: lvl = (cnt < p / 2) ? bv : ~bv;
            2'b10: begin
               if (cnt == 0) lvl = lvl ^ bv;
               if (cnt == p / 2) lvl = ~lvl;
            end
            default: lvl = bv;
         endcase
         per = lvl ? 10 : 8;
         if (cnt == 0 || lvl != plvl) sc = 0;
         else sc = (sc + 1) % per;
         flip = (md == 2'b10) ? ~bv : (bv ^ pbit);
         pbit = bv;
         m = model.mod_q[s + k];
         check(model.act_q[s + k], 1'b1);
         if (md == 2'b00)
            check(m, ~lvl);
         else if (md == 2'b01)
            check(m, (sc < per / 2) ? 1'b1 : 1'b0);
         else if (k > 0)
            check(m ^ model.mod_q[s + k - 1], ~(cnt == 0 && flip));
      end
      // split coding cuts level-one runs short, so only direct level shows both periods
      if (md == 2'b01 && cd == 2'b00) begin
         check(model.n8 > 0, 1'b1);
         check(model.n10 > 0, 1'b1);
      end
   endtask

   task automatic t_direct_nrz;
      run_case(2'b00, 2'b00, 3'h0, 2'b00, 16, 64, 65);
   endtask

   task automatic t_direct_split;
      run_case(2'b00, 2'b01, 3'h0, 2'b00, 16, 64, 65);
   endtask

   task automatic t_direct_biphase;
      run_case(2'b00, 2'b10, 3'h0, 2'b00, 16, 64, 65);
   endtask

   task automatic t_fsk_nrz;
      run_case(2'b01, 2'b00, 3'h0, 2'b00, 16, 64, 65);
   endtask

   task automatic t_fsk_split;
      run_case(2'b01, 2'b01, 3'h0, 2'b00, 16, 64, 65);
   endtask

   task automatic t_psk_zero;
      run_case(2'b10, 2'b00, 3'h0, 2'b00, 16, 64, 65);
   endtask

   task automatic t_psk_change;
      run_case(2'b11, 2'b00, 3'h0, 2'b00, 16, 64, 65);
   endtask

   // slower rate, longer loop, spare coding treated as direct level
   task automatic t_rate_len;
      run_case(2'b00, 2'b11, 3'h1, 2'b01, 32, 96, 97);
   endtask

   // array written under reset so no unknown bit reaches the buffer
   initial begin
      repeat (3) @(negedge core_clk_i);
      for (int i = 0; i < 128; i++) begin
         @(negedge core_clk_i);
         prog_we = 1'b1;
         prog_addr = i[6:0];
         prog_bit = pat[i];
      end
      @(negedge core_clk_i);
      prog_we = 1'b0;
      t_direct_nrz();
      t_direct_split();
      t_direct_biphase();
      t_fsk_nrz();
      t_fsk_split();
      t_psk_zero();
      t_psk_change();
      t_rate_len();
      end_of_test();
   end

   // about 84k cycles expected, cut off before 100k
   initial begin
      #780000;
      fail_count++;
      end_of_test();
   end
endmodule

// ===== testbench/rtbe_reader_model.sv
// Purpose: reader side of the air link, makes the carrier and samples the envelope
// Assumes: the carrier runs free while the reader field is on
// Notes: one sample per carrier rise shows the output set by the previous tick
`timescale 1ns/100ps
module rtbe_reader_model #(
   parameter real HALF_NS = 32.0
) (
   // carrier to the tag
   output logic carrier_clk_o,
   // tag side
   input wire logic rst_i,
   input wire logic mod_i,
   input wire logic tx_active_i
);
   logic mod_q[$];
   logic act_q[$];
   logic mod_prev;
   int gap;
   int since;
   int n8;
   int n10;

   initial begin
      carrier_clk_o = 1'b0;
      mod_prev = 1'b0;
      gap = 0;
      since = 0;
      n8 = 0;
      n10 = 0;
      #3;
      forever #(HALF_NS) carrier_clk_o = ~carrier_clk_o;
   end

   // capture restarts with each power-on reset
   always @(posedge rst_i) begin
      mod_q.delete();
      act_q.delete();
      n8 = 0;
      n10 = 0;
   end

   always @(posedge carrier_clk_o) begin
      if (!rst_i) begin
         mod_q.push_back(mod_i);
         act_q.push_back(tx_active_i);
      end
      // carrier cycles between damping edges tell eight from ten
      since = since + 1;
      if (mod_i && !mod_prev) begin
         gap = since;
         since = 0;
         if (!rst_i && gap == 8) begin
            n8 = n8 + 1;
         end
         if (!rst_i && gap == 10) begin
            n10 = n10 + 1;
         end
      end
      mod_prev = mod_i;
   end
endmodule
